//--- dv/aep_encoder_port_chk.sv
// concurrent checks on the encoder position port
`timescale 1ns/1ps
module aep_encoder_port_chk
   import aep_pkg::*;
#(
   parameter int unsigned ST_BITS    = 13,
   parameter int unsigned MT_BITS    = 12,
   parameter int unsigned SET_MIN    = SET_MIN_CYC,
   parameter int unsigned SET_DELAY  = SET_DELAY_CYC,
   parameter int unsigned STORE_TIME = STORE_CYC
)(
   input wire logic               core_clk,
   input wire logic               rst_b,
   input wire logic               ma_clk,
   input wire logic [ST_BITS-1:0] pos_single_turn,
   input wire logic [MT_BITS-1:0] pos_multi_turn,
   input wire aep_fault_t         fault_in,
   input wire logic               set_in,
   input wire logic               slo_out,
   input wire logic               status_n_out,
   input wire logic               status_oe,
   input wire logic               led_out,
   input wire logic               store_busy,
   input wire logic               inc_a,
   input wire logic               inc_b
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   localparam int DLY_MAX  = SET_DELAY + 8;        // acceptance to busy
   localparam int IDLE_END = MONO_CYC + 16;        // monoflop plus sync slack
   logic [CNT_W-1:0]  busy_cnt_ff, set_cnt_ff, nxt_busy_cnt, nxt_set_cnt, wait_cnt_ff, nxt_wait_cnt;
   logic [MONO_W-1:0] idle_cnt_ff, nxt_idle_cnt;
   logic              ma_clk_ff, set_ok_ff, nxt_set_ok, set_full;
   assign set_full     = (set_cnt_ff == CNT_W'(SET_MIN));
   assign nxt_busy_cnt = store_busy ? busy_cnt_ff + 1'b1 : '0;
   assign nxt_set_cnt  = !set_in ? '0 : (set_full ? set_cnt_ff : set_cnt_ff + 1'b1);
   assign nxt_set_ok   = !store_busy & (set_ok_ff | set_full);
   assign nxt_wait_cnt = set_ok_ff ? wait_cnt_ff + 1'b1 : '0;
   assign nxt_idle_cnt = (ma_clk != ma_clk_ff) ? '0 :
                         (idle_cnt_ff == MONO_W'(IDLE_END)) ? idle_cnt_ff : idle_cnt_ff + 1'b1;
   // count busy length, preset pulse length, preset wait and link quiet time
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt_ff <= '0;
         set_cnt_ff  <= '0;
         set_ok_ff   <= 1'b0;
         wait_cnt_ff <= '0;
         idle_cnt_ff <= '0;
         ma_clk_ff   <= 1'b1;
      end else begin
         busy_cnt_ff <= nxt_busy_cnt;
         set_cnt_ff  <= nxt_set_cnt;
         set_ok_ff   <= nxt_set_ok;
         wait_cnt_ff <= nxt_wait_cnt;
         idle_cnt_ff <= nxt_idle_cnt;
         ma_clk_ff   <= ma_clk;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_fault_set;  fault_in != 4'h0 |=> !status_n_out; endproperty
   property p_fault_hold; !status_n_out |=> !status_n_out; endproperty
   property p_status_pair; led_out == status_oe && status_oe == !status_n_out; endproperty
   property p_no_spur;    status_n_out && fault_in == 4'h0 |=> status_n_out; endproperty
   property p_busy_len;   $fell(store_busy) |-> busy_cnt_ff == CNT_W'(STORE_TIME); endproperty
   property p_busy_hold;  $rose(store_busy) |=> store_busy [*8]; endproperty
   property p_busy_cause; $rose(store_busy) |-> set_ok_ff; endproperty
   property p_busy_start; set_ok_ff |-> wait_cnt_ff <= CNT_W'(DLY_MAX); endproperty
   property p_slo_idle;   idle_cnt_ff == MONO_W'(IDLE_END) |-> slo_out; endproperty
   a_fault_set:
      assert property (p_fault_set) else $error("status not driven low after fault");
   a_fault_hold:
      assert property (p_fault_hold) else $error("fault indication released");
   a_status_pair:
      assert property (p_status_pair) else $error("led, enable and status disagree");
   a_no_spur:
      assert property (p_no_spur) else $error("status low without fault");
   a_busy_len:
      assert property (p_busy_len) else $error("storage window length wrong");
   a_busy_hold:
      assert property (p_busy_hold) else $error("storage window cut short");
   a_busy_cause:
      assert property (p_busy_cause) else $error("preset taken from short pulse");
   a_busy_start:
      assert property (p_busy_start) else $error("preset not applied in time");
   a_slo_idle:
      assert property (p_slo_idle) else $error("data line not high after timeout");
   c_fault:  cover property (!status_n_out);
   c_preset: cover property ($rose(store_busy));
   c_frame:  cover property ($fell(ma_clk));
endmodule
bind aep_encoder_port aep_encoder_port_chk #(.ST_BITS(ST_BITS), .MT_BITS(MT_BITS), .SET_MIN(SET_MIN),
   .SET_DELAY(SET_DELAY), .STORE_TIME(STORE_TIME)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .ma_clk(ma_clk), .pos_single_turn(pos_single_turn), .pos_multi_turn(pos_multi_turn),
   .fault_in(fault_in), .set_in(set_in), .slo_out(slo_out), .status_n_out(status_n_out),
   .status_oe(status_oe), .led_out(led_out), .store_busy(store_busy), .inc_a(inc_a), .inc_b(inc_b));

//--- dv/aep_encoder_port_test.sv
// self-checking bench for the encoder position port
`timescale 1ns/1ps
module aep_encoder_port_test
   import aep_pkg::*;
;
   logic        core_clk, rst_b, set_in, ma_clk, slo_out, status_n_out, status_oe;
   logic        led_out, store_busy, inc_a, inc_b;
   logic        b_clk, b_slo, b_inc_a, b_inc_b;  // second port, other link mode
   logic [12:0] st_pos;    // singleturn count
   logic [11:0] mt_pos;    // multiturn count
   aep_fault_t  fault;     // fault levels
   logic [63:0] word;      // last frame read
   int          n_errors = 0;
   int          n_tests  = 0;
   aep_encoder_port #(.SET_MIN(20), .SET_DELAY(10), .STORE_TIME(30)) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .ma_clk(ma_clk), .pos_single_turn(st_pos),
      .pos_multi_turn(mt_pos), .fault_in(fault), .set_in(set_in), .slo_out(slo_out),
      .status_n_out(status_n_out), .status_oe(status_oe), .led_out(led_out),
      .store_busy(store_busy), .inc_a(inc_a), .inc_b(inc_b));
   aep_ssi_master u_mst (.ma_clk(ma_clk), .slo(slo_out));
   // reversed direction, no incremental track
   aep_encoder_port #(.MODE(AEP_BISS), .DIR_REV(1'h1), .INC_FITTED(1'h0), .SET_MIN(20), .SET_DELAY(10),
      .STORE_TIME(30)) DUT_BISS (
      .core_clk(core_clk), .rst_b(rst_b), .ma_clk(b_clk), .pos_single_turn(st_pos),
      .pos_multi_turn(mt_pos), .fault_in(fault), .set_in(set_in), .slo_out(b_slo),
      .status_n_out(), .status_oe(), .led_out(), .store_busy(), .inc_a(b_inc_a), .inc_b(b_inc_b));
   aep_ssi_master #(.MIN_HALF(50.0)) u_bmst (.ma_clk(b_clk), .slo(b_slo));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic do_reset();
      cyc(1);
      rst_b = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      cyc(2);
   endtask
   // 25 position bits then the low gap bit
   task automatic read_chk(input string what, input logic [24:0] exp, input realtime half);
      u_mst.read_frame(26, half, word);
      chk(what, {38'h0, exp, 1'h0}, word);
   endtask
   task automatic t_incr();
      logic [1:0] q;
      for (int i = 0; i < 4; i++) begin
         q = 2'(i);
         cyc(1);
         st_pos = {11'h0, q};
         cyc(130);
         chk("quadrature", {62'h0, q[1], q[1] ^ q[0]}, {62'h0, inc_a, inc_b});
      end
   endtask
   task automatic t_frame();
      cyc(1);
      st_pos = 13'h1A5B;
      mt_pos = 12'hC3E;
      cyc(2100);
      read_chk("frame", {12'hC3E, 13'h1A5B}, 250.0);
      cyc(1);
      st_pos = 13'h0777;
      read_chk("repeat", {12'hC3E, 13'h1A5B}, 250.0);
   endtask
   task automatic t_fresh();
      cyc(1);
      mt_pos = 12'h001;
      cyc(2100);
      chk("slo idle", 64'h1, {63'h0, slo_out});
      read_chk("fresh", {12'h001, 13'h0777}, 1000.0);
   endtask
   // reference crc, x^6 + x + 1 from zero, msb first
   function automatic logic [5:0] crc_ref(input logic [26:0] d);
      logic [5:0] c;
      logic       fb;
      c = 6'h00;
      for (int i = 26; i >= 0; i--) begin
         fb = c[5] ^ d[i];
         c  = {c[4:1], c[0] ^ fb, fb};
      end
      return c;
   endfunction
   // ack, start, cds, position, error, warning, inverted crc, gap
   task automatic t_biss();
      logic [24:0] p;
      p = 25'h1FFD889; // two's complement of {001, 0777}
      u_bmst.read_frame(37, 50.0, word);
      chk("biss", {27'h0, 3'h2, p, 2'h3, ~crc_ref({p, 2'h3}), 1'h0}, word);
      chk("no incremental", 64'h0, {62'h0, b_inc_a, b_inc_b});
   endtask
   task automatic t_preset();
      int k;
      cyc(1);
      set_in = 1'b1;
      cyc(10);
      set_in = 1'b0;
      cyc(50);
      chk("short set", 64'h0, {63'h0, store_busy});
      set_in = 1'b1;
      cyc(25);
      set_in = 1'b0;
      k = 0;
      while (store_busy !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      chk("busy rise", 64'h1, {63'h0, store_busy});
      cyc(20);
      chk("busy hold", 64'h1, {63'h0, store_busy});
      cyc(20);
      chk("busy end", 64'h0, {63'h0, store_busy});
      cyc(2100);
      read_chk("preset", 25'h0, 250.0);
      cyc(1);
      st_pos = st_pos + 13'h5;
      cyc(2100);
      read_chk("offset", 25'h5, 250.0);
   endtask
   task automatic t_fault();
      for (int b = 0; b < 4; b++) begin
         do_reset();
         chk("no fault", 64'h1, {61'h0, led_out, status_oe, status_n_out});
         fault = aep_fault_t'(4'h1 << b);
         cyc(1);
         fault = '0;
         cyc(20);
         chk("fault", 64'h7, {61'h0, led_out, status_oe, ~status_n_out});
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      set_in = 1'b0;
      st_pos = 13'h0;
      mt_pos = 12'h0;
      fault = '0;
      do_reset();
      t_incr();
      t_frame();
      t_fresh();
      t_biss();
      t_preset();
      t_fault();
      test_done();
   end
   // cut a hang short well beyond the expected run time
   initial begin
      #400000;
      n_errors++;
      $display("ERROR watchdog expected done seen timeout");
      test_done();
   end
endmodule

//--- dv/aep_ssi_master.sv
// serial position master that clocks frames out of the encoder
`timescale 1ns/1ps
module aep_ssi_master
#(
   parameter real MIN_HALF = 250.0 // 2 MHz for SSI; a 10 MHz link passes 50 ns
)(
   output logic      ma_clk,
   input  wire logic slo
);
   initial ma_clk = 1'b1; // link clock rests high outside frames
   // clock n bits msb first, sampling each bit before the next fall
   task automatic read_frame(input int n, input realtime half, output logic [63:0] word);
      if (half < MIN_HALF) half = MIN_HALF;
      word = '0;
      for (int i = 0; i < n; i++) begin
         ma_clk = 1'b0;
         #half;
         ma_clk = 1'b1;
         #half;
         word = {word[62:0], slo};
      end
   endtask
endmodule

//--- logic/aep_encoder_port.sv
// position output port of a multiturn absolute encoder
`timescale 1ns/1ps

module aep_encoder_port
   import aep_pkg::*;
#(
   parameter aep_mode_t                 MODE       = AEP_SSI,
   parameter logic                      GRAY_CODE  = 1'h0,
   parameter logic                      DIR_REV    = 1'h0,
   parameter int unsigned               ST_BITS    = 13,
   parameter int unsigned               MT_BITS    = 12,
   parameter logic [POS_MAX_BITS-1:0]   PRESET_VAL = '0,
   parameter logic                      INC_FITTED = 1'h1,
   parameter int unsigned               SET_MIN    = SET_MIN_CYC,
   parameter int unsigned               SET_DELAY  = SET_DELAY_CYC,
   parameter int unsigned               STORE_TIME = STORE_CYC
)(
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire logic                 ma_clk,
   input  wire logic [ST_BITS-1:0]   pos_single_turn,
   input  wire logic [MT_BITS-1:0]   pos_multi_turn,
   input  wire aep_fault_t           fault_in,
   input  wire logic                 set_in,
   output logic                      slo_out,
   output logic                      status_n_out,
   output logic                      status_oe,
   output logic                      led_out,
   output logic                      store_busy,
   output logic                      inc_a,
   output logic                      inc_b
);

   // ---------------------------------------------------------------
   // derived sizes
   // ---------------------------------------------------------------
   localparam int unsigned POS_W    = ST_BITS + MT_BITS;
   localparam int unsigned BISS_LEN = BISS_HDR_W + POS_W + BISS_TAIL_W + CRC_W;
   localparam int unsigned REFR_CYC = (ST_BITS < ST_SLOW_BITS) ? REFR_FAST_CYC : REFR_SLOW_CYC;
   localparam logic [REFR_W-1:0] REFR_LAST  = REFR_W'(REFR_CYC - 1);
   localparam logic [CNT_W-1:0]  SET_LAST   = CNT_W'(SET_MIN - 1);
   localparam logic [CNT_W-1:0]  DELAY_LAST = CNT_W'(SET_DELAY - 1);
   localparam logic [CNT_W-1:0]  STORE_LAST = CNT_W'(STORE_TIME - 1);
   localparam logic [POS_W-1:0]  PRESET_W   = PRESET_VAL[POS_W-1:0];

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // crc over position, error and warning bits, msb first
   function automatic logic [CRC_W-1:0] crc6(input logic [POS_W+1:0] d);
      logic [CRC_W-1:0] c;
      logic             fb;
      c = '0;
      for (int i = POS_W + 1; i >= 0; i--) begin
         fb = c[CRC_W-1] ^ d[i];
         c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
      return c;
   endfunction

   // binary to reflected gray
   function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic clk_s1_ff;                                  // link clock, first stage
   logic clk_s2_ff;                                  // link clock, second stage
   logic clk_s3_ff;                                  // edge detect history
   logic set_s1_ff;                                  // preset pin, first stage
   logic set_s2_ff;                                  // preset pin, second stage
   logic set_s3_ff;                                  // preset edge history

   // two flops before any core logic reads the link clock or preset pin
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_s1_ff <= 1'b1;
         clk_s2_ff <= 1'b1;
         clk_s3_ff <= 1'b1;
         set_s1_ff <= 1'b0;
         set_s2_ff <= 1'b0;
         set_s3_ff <= 1'b0;
      end else begin
         clk_s1_ff <= ma_clk;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
         set_s1_ff <= set_in;
         set_s2_ff <= set_s1_ff;
         set_s3_ff <= set_s2_ff;
      end
   end

   // ---------------------------------------------------------------
   // monoflop and frame framing
   // ---------------------------------------------------------------
   logic [MONO_W-1:0] mono_cnt_ff;                   // cycles since last edge
   logic              run_ff;                        // frame in progress
   logic              cdm_ff;                        // last bit the master sent

   wire               clk_edge     = clk_s2_ff ^ clk_s3_ff;
   wire               clk_fall     = clk_s3_ff & ~clk_s2_ff;
   wire               mono_done    = (mono_cnt_ff == MONO_CNT);
   wire               mono_expire  = run_ff & mono_done;
   wire [MONO_W-1:0]  nxt_mono_cnt = clk_edge ? '0 : (mono_done ? mono_cnt_ff : mono_cnt_ff + 1'b1);
   // first falling edge starts a frame and wins over expiry
   wire               nxt_run      = clk_fall | (run_ff & ~mono_done);
   // master holds the clock low through the timeout to send a one
   wire               nxt_cdm      = mono_expire ? ~clk_s2_ff : cdm_ff;

   // every edge retriggers the monoflop
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mono_cnt_ff <= MONO_CNT;
         run_ff      <= 1'b0;
         cdm_ff      <= 1'b0;
      end else begin
         mono_cnt_ff <= nxt_mono_cnt;
         run_ff      <= nxt_run;
         cdm_ff      <= nxt_cdm;
      end
   end

   // ---------------------------------------------------------------
   // position path and refresh
   // ---------------------------------------------------------------
   logic [REFR_W-1:0] refr_cnt_ff;                   // refresh divider
   logic [POS_W-1:0]  off_ff;                        // preset offset
   logic [POS_W-1:0]  sample_ff;                     // refreshed position

   wire [POS_W-1:0]   pos_raw      = {pos_multi_turn, pos_single_turn};
   wire [POS_W-1:0]   pos_dir      = DIR_REV ? (~pos_raw + 1'b1) : pos_raw;
   wire [POS_W-1:0]   pos_live     = pos_dir + off_ff;
   wire               refr_tick    = (refr_cnt_ff == REFR_LAST);
   wire [REFR_W-1:0]  nxt_refr_cnt = refr_tick ? '0 : refr_cnt_ff + 1'b1;
   // fresh sample every 1 us or 4 us by singleturn width
   wire [POS_W-1:0]   nxt_sample   = refr_tick ? pos_live : sample_ff;

   // ---------------------------------------------------------------
   // preset sequencer
   // ---------------------------------------------------------------
   aep_preset_state_t pre_state_ff;                  // preset progress
   aep_preset_state_t nxt_pre_state;
   logic [CNT_W-1:0]  pre_cnt_ff;                    // time within state
   logic [CNT_W-1:0]  nxt_pre_cnt;

   wire               set_rise     = set_s2_ff & ~set_s3_ff;
   wire               pre_apply    = (pre_state_ff == PS_DELAY) && (pre_cnt_ff == DELAY_LAST);
   // load zero or the factory value whatever the angle
   wire [POS_W-1:0]   nxt_off      = pre_apply ? (PRESET_W - pos_dir) : off_ff;

   // pulse shorter than the least width is dropped
   always_comb begin
      nxt_pre_state = pre_state_ff;
      nxt_pre_cnt   = pre_cnt_ff + 1'b1;
      case (pre_state_ff)
         PS_IDLE: begin
            nxt_pre_cnt = '0;
            if (set_rise) begin
               nxt_pre_state = PS_HOLD;
            end
         end
         PS_HOLD: begin
            if (!set_s2_ff) begin
               nxt_pre_state = PS_IDLE;
            end else if (pre_cnt_ff == SET_LAST) begin
               nxt_pre_state = PS_DELAY;
               nxt_pre_cnt   = '0;
            end
         end
         PS_DELAY: begin
            // new value in the word 1 ms after acceptance
            if (pre_apply) begin
               nxt_pre_state = PS_STORE;
               nxt_pre_cnt   = '0;
            end
         end
         PS_STORE: begin
            // storage window, power must stay on
            if (pre_cnt_ff == STORE_LAST) begin
               nxt_pre_state = PS_IDLE;
               nxt_pre_cnt   = '0;
            end
         end
         default: begin
            nxt_pre_state = PS_IDLE;
            nxt_pre_cnt   = '0;
         end
      endcase
   end

   // preset state, offset, refresh
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_state_ff <= PS_IDLE;
         pre_cnt_ff   <= '0;
         off_ff       <= '0;
         refr_cnt_ff  <= '0;
         sample_ff    <= '0;
      end else begin
         pre_state_ff <= nxt_pre_state;
         pre_cnt_ff   <= nxt_pre_cnt;
         off_ff       <= nxt_off;
         refr_cnt_ff  <= nxt_refr_cnt;
         sample_ff    <= nxt_sample;
      end
   end

   // ---------------------------------------------------------------
   // fault latch
   // ---------------------------------------------------------------
   logic fault_ff;                                   // any fault seen
   // any fault source sets, only power-on reset clears
   wire  nxt_fault = fault_ff | (|fault_in);

   // ---------------------------------------------------------------
   // frame build, frozen while a frame runs
   // ---------------------------------------------------------------
   aep_frame_t        frame_ff;                      // word handed to the link
   aep_frame_t        nxt_frame;
   wire               err_n      = ~fault_ff;
   wire               warn_n     = 1'b1;
   wire [POS_W+1:0]   crc_data   = {sample_ff, err_n, warn_n};
   wire [CRC_W-1:0]   crc_val    = crc6(crc_data);
   wire [POS_W-1:0]   ssi_word   = GRAY_CODE ? to_gray(sample_ff) : sample_ff;
   wire [BISS_LEN-1:0] biss_word = {BISS_ACK, BISS_START, cdm_ff, crc_data, ~crc_val};
   wire [FRAME_W-1:0] ssi_bits   = {ssi_word, {(FRAME_W - POS_W){1'b0}}};
   wire [FRAME_W-1:0] biss_bits  = {biss_word, {(FRAME_W - BISS_LEN){1'b0}}};

   // msb first; the copy stops once the first edge is seen
   assign nxt_frame.bits = (MODE == AEP_BISS) ? biss_bits : ssi_bits;
   assign nxt_frame.len  = (MODE == AEP_BISS) ? LEN_W'(BISS_LEN) : LEN_W'(POS_W);

   // idle: track the newest sample; running: hold it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_ff <= '0;
         fault_ff <= 1'b0;
      end else begin
         frame_ff <= run_ff ? frame_ff : nxt_frame;
         fault_ff <= nxt_fault;
      end
   end

   // ---------------------------------------------------------------
   // link domain
   // ---------------------------------------------------------------
   // run_ff is the shifter's reset: released after the first edge,
   // reasserted by the monoflop, so a stopped clock needs no edge
   aep_link_shifter u_shifter (
      .ma_clk (ma_clk),
      .run    (run_ff),
      .frame  (frame_ff),
      .slo    (slo_out)
   );

   // ---------------------------------------------------------------
   // incremental track
   // ---------------------------------------------------------------
   wire [INC_ANG_W-1:0] inc_ang  = INC_ANG_W'(pos_live[ST_BITS-1:0]) << (INC_ANG_W - ST_BITS);
   wire [1:0]           inc_quad = inc_ang[INC_LSB+1:INC_LSB];
   wire                 nxt_a    = INC_FITTED & inc_quad[1];
   wire                 nxt_b    = INC_FITTED & (inc_quad[1] ^ inc_quad[0]);

   // ---------------------------------------------------------------
   // registered pin outputs
   // ---------------------------------------------------------------
   // status pulls low and LED lights only on a latched fault
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_n_out <= 1'b1;
         status_oe    <= 1'b0;
         led_out      <= 1'b0;
         store_busy   <= 1'b0;
         inc_a        <= 1'b0;
         inc_b        <= 1'b0;
      end else begin
         status_n_out <= ~nxt_fault;
         status_oe    <= nxt_fault;
         led_out      <= nxt_fault;
         store_busy   <= (nxt_pre_state == PS_STORE);
         inc_a        <= nxt_a;
         inc_b        <= nxt_b;
      end
   end

endmodule

//--- logic/aep_link_shifter.sv
// link side shifter clocked by the master's serial clock
`timescale 1ns/1ps
module aep_link_shifter
   import aep_pkg::*;
(
   input  wire logic       ma_clk,
   input  wire logic       run,
   input  wire aep_frame_t frame,
   output logic            slo
);

   // ---------------------------------------------------------------
   // bit pointer
   // ---------------------------------------------------------------
   logic [LEN_W-1:0] bit_cnt_ff;                     // next bit to send
   wire              at_end   = (bit_cnt_ff == frame.len);
   wire  [LEN_W-1:0] bit_idx  = LEN_W'(FRAME_W - 1) - bit_cnt_ff;
   wire  [LEN_W-1:0] nxt_cnt  = at_end ? '0 : bit_cnt_ff + 1'b1;
   wire              nxt_slo  = at_end ? LINE_LOW : frame.bits[bit_idx];

   // one bit per rising edge, at any rate whose half period stays inside the monoflop time
   // after the last bit one low gap, then the same frame again
   // run low (monoflop expired) parks the line high
   always_ff @(posedge ma_clk or negedge run) begin
      if (!run) begin
         bit_cnt_ff <= '0;
         slo        <= LINE_IDLE;
      end else begin
         bit_cnt_ff <= nxt_cnt;
         slo        <= nxt_slo;
      end
   end

endmodule

//--- shared/aep_pkg.sv
// shared constants and types for the absolute encoder position port
package aep_pkg;

   // ---------------------------------------------------------------
   // core clock and derived timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;        // core_clk period
   localparam int unsigned MONO_TIME_US  = 15;       // monoflop, longest
   localparam int unsigned MONO_CYC      = (MONO_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned REFR_FAST_US  = 1;        // refresh at narrow singleturn
   localparam int unsigned REFR_SLOW_US  = 4;        // refresh at wide singleturn
   localparam int unsigned REFR_FAST_CYC = (REFR_FAST_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned REFR_SLOW_CYC = (REFR_SLOW_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned SET_MIN_MS    = 10;       // least preset pulse
   localparam int unsigned SET_DELAY_MS  = 1;        // preset to new data
   localparam int unsigned STORE_MS      = 200;      // internal storage time
   localparam int unsigned SET_MIN_CYC   = (SET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SET_DELAY_CYC = (SET_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned STORE_CYC     = (STORE_MS * 1000000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // counter widths
   // ---------------------------------------------------------------
   localparam int unsigned MONO_W = 11;              // holds MONO_CYC
   localparam int unsigned REFR_W = 10;              // holds REFR_SLOW_CYC
   localparam int unsigned CNT_W  = 25;              // holds STORE_CYC
   localparam logic [MONO_W-1:0] MONO_CNT = MONO_W'(MONO_CYC);

   // ---------------------------------------------------------------
   // position word and frame layout
   // ---------------------------------------------------------------
   localparam int unsigned ST_SLOW_BITS = 15;        // slow refresh from here
   localparam int unsigned POS_MAX_BITS = 41;        // widest position word
   localparam int unsigned FRAME_W      = 53;        // frame buffer, msb first
   localparam int unsigned LEN_W        = 6;         // frame length field
   localparam int unsigned BISS_HDR_W   = 3;         // ack, start, cds
   localparam int unsigned BISS_TAIL_W  = 2;         // error, warning
   localparam int unsigned CRC_W        = 6;
   localparam logic [CRC_W-1:0] CRC_POLY = 6'h03;    // x^6 + x + 1
   localparam logic BISS_ACK   = 1'h0;
   localparam logic BISS_START = 1'h1;
   localparam logic LINE_IDLE  = 1'h1;               // data line at rest
   localparam logic LINE_LOW   = 1'h0;               // gap and tail level

   // ---------------------------------------------------------------
   // incremental track
   // ---------------------------------------------------------------
   localparam int unsigned INC_ANG_W = 17;           // angle scaled to 17 bits
   localparam int unsigned INC_LSB   = 4;            // 2048 pulses, 4 states each

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {AEP_SSI, AEP_BISS} aep_mode_t;

   typedef enum logic [1:0] {PS_IDLE, PS_HOLD, PS_DELAY, PS_STORE} aep_preset_state_t;

   typedef struct packed {
      logic single_turn;                             // singleturn sensing error
      logic multi_turn;                              // multiturn sensing error
      logic light;                                   // light source failure
      logic temp;                                    // over or under temperature
   } aep_fault_t;

   typedef struct packed {
      logic [FRAME_W-1:0] bits;                      // msb goes out first
      logic [LEN_W-1:0]   len;                       // bits before the gap
   } aep_frame_t;

endpackage
